/* File: pads_pkg.sv */
// Purpose: Shared constants and carrier types for the phase-angle dimmer scheduler
// Assumes: 40 MHz system clock
// Notes:   All timing figures are kept in their own units and converted here

package pads_pkg;

    // System clock
    localparam int unsigned CLK_HZ       = 40_000_000;
    // Scheduler tick period in nanoseconds
    localparam int unsigned TICK_NS      = 53_000;
    // Tick length in clock cycles, rounded down, never below one
    localparam int unsigned TICK_CYC_RAW = (TICK_NS / 25);
    localparam int unsigned TICK_CYC     = (TICK_CYC_RAW < 1) ? 1 : TICK_CYC_RAW;
    // Firing pulse length in nanoseconds
    localparam int unsigned PULSE_NS     = 10_000;
    localparam int unsigned PULSE_CYC    = (PULSE_NS / 25 < 1) ? 1 : PULSE_NS / 25;

    // Channel count and delay width
    localparam int unsigned NUM_CH   = 12;
    localparam int unsigned DLY_W    = 8;
    // Highest useful delay values per mains frequency
    localparam logic [7:0]  DLY_MAX_50HZ = 8'hbc;
    localparam logic [7:0]  DLY_MAX_60HZ = 8'h9c;
    // Output index where channel one lands
    localparam int unsigned FIRST_OUT = 5;
    localparam int unsigned LAST_OUT  = 16;

    // Channel mode codes
    typedef enum logic [1:0] {
        PADS_MODE_OFF = 2'b00,
        PADS_MODE_ON  = 2'b01,
        PADS_MODE_DIM = 2'b10
    } pads_mode_t;

    // Per-channel setting carried from the controller
    typedef struct packed {
        pads_mode_t       mode;
        logic [DLY_W-1:0] delay;
    } pads_ch_cfg_t;

    // Zero-crossing status carried to the controller
    typedef struct packed {
        logic crossing_seen;
        logic input_dedicated;
    } pads_zc_stat_t;

endpackage : pads_pkg

/* File: pads_channel.sv */
// Purpose: One dimmer channel: counts ticks from the crossing and fires once
// Assumes: Tick and crossing strobes are one-cycle pulses on i_clk
// Notes:   Output is registered so the top drives its pins straight from flops

`timescale 1ns/1ps
`default_nettype none

module pads_channel #(
    parameter int unsigned DLY_W     = 8,
    parameter int unsigned PULSE_CYC = 400
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    // Timing strobes
    input  wire logic             i_zc,
    input  wire logic             i_tick,
    input  wire logic             i_arm,
    // Setting
    input  wire pads_pkg::pads_ch_cfg_t i_cfg,
    // Output drive
    output logic                  o_drive
);

    localparam int unsigned PW = $clog2(PULSE_CYC + 1);

    logic [DLY_W-1:0] cnt_q, cnt_d;
    logic             wait_q, wait_d;
    logic [PW-1:0]    pls_q, pls_d;
    logic             drive_q, drive_d;

    // Next state of the delay counter and pulse timer
    always_comb begin
        cnt_d   = cnt_q;
        wait_d  = wait_q;
        pls_d   = pls_q;
        drive_d = 1'b0;
        if (pls_q != '0) begin
            pls_d = pls_q - PW'(1);
        end
        // [RQ13] Restart on crossing
        // [RQ3] Repeat every half cycle
        if (i_zc) begin
            wait_d = i_arm && (i_cfg.mode == pads_pkg::PADS_MODE_DIM)
                     && (i_cfg.delay != '0);     // Zero delay never schedules
            cnt_d  = DLY_W'(i_cfg.delay);
            pls_d  = '0;                          // Cancel a late pulse too
        end else if (wait_q && i_tick) begin
            // [RQ9] Count whole ticks
            if (cnt_q <= DLY_W'(1)) begin
                // [RQ2] Fire after delay
                wait_d = 1'b0;
                pls_d  = PW'(PULSE_CYC);
            end else begin
                cnt_d = cnt_q - DLY_W'(1);
            end
        end
        // [RQ5] Full on or off
        case (i_cfg.mode)
            pads_pkg::PADS_MODE_ON:  drive_d = 1'b1;
            pads_pkg::PADS_MODE_DIM: drive_d = (pls_d != '0);
            default:                 drive_d = 1'b0;
        endcase
    end

    // Register the channel state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q   <= '0;
            wait_q  <= 1'b0;
            pls_q   <= '0;
            drive_q <= 1'b0;
        end else if (i_ce) begin
            cnt_q   <= cnt_d;
            wait_q  <= wait_d;
            pls_q   <= pls_d;
            drive_q <= drive_d;
        end
    end

    assign o_drive = drive_q;

endmodule : pads_channel

`default_nettype wire

/* File: pads_top.sv */
// Purpose: Phase-angle dimmer scheduler with twelve firing outputs
// Assumes: Crossing input is already synchronous and conditioned externally
// Notes:   Outputs 5..16 of the device map to o_fire[0..11]

`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RQ1] A falling edge on the crossing input starts a new round for every active channel.
// [RQ2] After each crossing a channel waits its delay then emits one short firing pulse.
// [RQ3] The delay and fire sequence repeats at every crossing while the channel dims.
// [RQ4] Twelve independent channels each drive one of outputs five to sixteen.
// [RQ5] A channel held on drives a steady level and a channel held off stays low.
// [RQ6] While dimming is enabled the crossing input is reserved and withheld from counters.
// [RQ7] A shorter delay fires earlier in the half cycle and gives a brighter lamp.
// [RQ8] The external relay must be of the non-zero-crossing type.
// [RQ9] Each delay counts whole ticks of about 53 us from the last crossing, zero not allowed.
// [RQ10] Software keeps delays within 1..188 at 50 Hz and 1..156 at 60 Hz.
// [RQ11] Channel one drives output five and channel twelve drives output sixteen in order.
// [RQ12] No firing is scheduled while the crossing interrupt is disabled.
// [RQ13] A pulse not yet fired at the next crossing is cancelled and rescheduled.
module pads_top #(
    parameter int unsigned NUM_CH    = pads_pkg::NUM_CH,
    parameter int unsigned DLY_W     = pads_pkg::DLY_W,
    parameter int unsigned TICK_CYC  = pads_pkg::TICK_CYC,
    parameter int unsigned PULSE_CYC = pads_pkg::PULSE_CYC
) (
    // Clock, reset, enable
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_ce,
    // Crossing detector and its enable
    input  wire logic                   i_zc_n,
    input  wire logic                   i_zc_irq_en,
    // Per-channel settings, index 0 is channel one
    input  wire pads_pkg::pads_ch_cfg_t i_cfg [NUM_CH],
    // Firing outputs, index 0 is output five
    output logic [NUM_CH-1:0]           o_fire,
    // Crossing input passed on when not reserved
    output logic                        o_zc_for_counter,
    output pads_pkg::pads_zc_stat_t     o_zc_stat
);

    localparam int unsigned TW = $clog2(TICK_CYC + 1);

    typedef enum logic [1:0] {
        PADS_ST_IDLE = 2'b00,
        PADS_ST_RUN  = 2'b01
    } pads_state_t;

    pads_state_t      st_q, st_d;
    logic             zc_prev_q, zc_prev_d;
    logic             zc_pulse_q, zc_pulse_d;
    logic [TW-1:0]    tick_cnt_q, tick_cnt_d;
    logic             tick_q, tick_d;
    logic             pass_q, pass_d;
    pads_pkg::pads_zc_stat_t stat_q, stat_d;
    logic [NUM_CH-1:0] drv;

    // Crossing edge, tick base and scheduler state
    always_comb begin
        st_d       = st_q;
        zc_prev_d  = i_zc_n;
        zc_pulse_d = 1'b0;
        tick_cnt_d = tick_cnt_q;
        tick_d     = 1'b0;
        pass_d     = i_zc_n;
        stat_d     = stat_q;
        case (st_q)
            PADS_ST_IDLE: begin
                // [RQ12] Disabled means no scheduling
                if (i_zc_irq_en) begin
                    st_d = PADS_ST_RUN;
                end
            end
            PADS_ST_RUN: begin
                if (!i_zc_irq_en) begin
                    st_d = PADS_ST_IDLE;
                end
            end
            default: st_d = PADS_ST_IDLE;
        endcase
        // [RQ1] Falling edge starts round
        if (st_q == PADS_ST_RUN && zc_prev_q && !i_zc_n) begin
            zc_pulse_d = 1'b1;
            tick_cnt_d = '0;                     // Ticks measured from the crossing
        end else if (tick_cnt_q >= TW'(TICK_CYC - 1)) begin
            tick_cnt_d = '0;
            tick_d     = 1'b1;
        end else begin
            tick_cnt_d = tick_cnt_q + TW'(1);
        end
        // [RQ6] Input reserved while dimming
        // Also forced on the entry cycle so the status flag and the pass path agree
        if (st_q == PADS_ST_RUN || st_d == PADS_ST_RUN) begin
            pass_d = 1'b1;                       // Idle level, counters see nothing
        end
        stat_d.input_dedicated = (st_d == PADS_ST_RUN);
        // Sticky until dimming stops; set wins
        if (zc_pulse_d) begin
            stat_d.crossing_seen = 1'b1;
        end else if (st_d == PADS_ST_IDLE) begin
            stat_d.crossing_seen = 1'b0;
        end
    end

    // Register scheduler state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q       <= PADS_ST_IDLE;
            zc_prev_q  <= 1'b1;
            zc_pulse_q <= 1'b0;
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
            pass_q     <= 1'b1;
            stat_q     <= '0;
        end else if (i_ce) begin
            st_q       <= st_d;
            zc_prev_q  <= zc_prev_d;
            zc_pulse_q <= zc_pulse_d;
            tick_cnt_q <= tick_cnt_d;
            tick_q     <= tick_d;
            pass_q     <= pass_d;
            stat_q     <= stat_d;
        end
    end

    // [RQ4] Twelve independent channels
    // [RQ11] Channel n to output n+4
    // [RQ7] Short delay fires early
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            pads_channel #(
                .DLY_W     (DLY_W),
                .PULSE_CYC (PULSE_CYC)
            ) u_ch (
                .i_clk   (i_clk),
                .i_rst   (i_rst),
                .i_ce    (i_ce),
                .i_zc    (zc_pulse_q),
                .i_tick  (tick_q),
                .i_arm   (st_q == PADS_ST_RUN),
                .i_cfg   (i_cfg[g]),
                .o_drive (drv[g])
            );
        end
    endgenerate

    assign o_fire           = drv;
    assign o_zc_for_counter = pass_q;
    assign o_zc_stat        = stat_q;

    // Assertions
    // [RQ12] No pulse while disabled
    a_idle_no_round: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ12]
        (i_ce && st_q == PADS_ST_IDLE) |=> !zc_pulse_q)
        else $error("crossing round started while disabled");

    sequence s_fall;
        i_ce && st_q == PADS_ST_RUN && zc_prev_q && !i_zc_n;
    endsequence
    // [RQ1] Edge gives round start
    a_fall_starts_round: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ1]
        s_fall |=> zc_pulse_q)
        else $error("falling edge did not start a round");

    // [RQ6] Counter path held idle
    a_zc_reserved: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ6]
        (i_ce && st_q == PADS_ST_RUN) |=> o_zc_for_counter)
        else $error("crossing leaked to counter while dimming");

    // [RQ5] Held on is steady
    a_held_on_level: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ5]
        (i_ce && i_cfg[0].mode == pads_pkg::PADS_MODE_ON) |=> o_fire[0])
        else $error("held-on channel not driven");

    // [RQ5] Held off is dark
    a_held_off_dark: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ5]
        (i_ce && i_cfg[0].mode == pads_pkg::PADS_MODE_OFF) |=> !o_fire[0])
        else $error("held-off channel driven");

    // [RQ9] Zero delay never arms
    sequence s_zero_dly_zc;
        i_ce && zc_pulse_q && i_cfg[0].mode == pads_pkg::PADS_MODE_DIM
        && i_cfg[0].delay == '0;
    endsequence
    a_zero_delay_quiet: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ9]
        s_zero_dly_zc |=> !g_ch[0].u_ch.wait_q)
        else $error("zero delay armed a firing");

    // [RQ13] Crossing cancels pulse
    a_zc_cancels: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ13]
        (i_ce && zc_pulse_q && i_cfg[0].mode == pads_pkg::PADS_MODE_DIM) |=> !o_fire[0])
        else $error("pulse survived a new crossing");

    // [RQ2] Dimming pulse is short
    a_pulse_short: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ2]
        (i_cfg[0].mode == pads_pkg::PADS_MODE_DIM && $rose(o_fire[0]))
        |-> (g_ch[0].u_ch.pls_q == PULSE_CYC))
        else $error("dimming pulse did not start with its full length");

    // [RQ3] Dim channel rearms
    a_dim_rearms: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ3]
        (i_ce && zc_pulse_q && st_q == PADS_ST_RUN
         && i_cfg[0].mode == pads_pkg::PADS_MODE_DIM && i_cfg[0].delay != '0)
        |=> g_ch[0].u_ch.wait_q)
        else $error("dimming channel not rearmed at crossing");

    // [RQ9] Delay loaded at crossing
    a_delay_loaded: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ9]
        (i_ce && zc_pulse_q) |=> (g_ch[0].u_ch.cnt_q == $past(i_cfg[0].delay)))
        else $error("delay not loaded at crossing");

    // [RQ1] Tick base restarts
    a_tick_restart: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ1]
        s_fall |=> (tick_cnt_q == '0 && !tick_q))
        else $error("tick base not restarted at crossing");

    // [RQ11] Last channel on last output
    a_last_ch_out: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ11]
        (i_ce && i_cfg[NUM_CH-1].mode == pads_pkg::PADS_MODE_ON) |=> o_fire[NUM_CH-1])
        else $error("last channel not on its own output");

endmodule : pads_top

`default_nettype wire

/* File: pads_mains_model.sv */
// Purpose: Far side model: crossing detector and twelve relays
// Assumes: Half period is given in clock cycles
// Notes:   Crossing line stays low for two cycles per crossing
`timescale 1ns/1ps
`default_nettype none
module pads_mains_model (
    // Control
    input  wire logic        i_clk,
    input  wire logic        i_run,
    input  wire logic [15:0] i_half,
    // Relay gates, crossing line, lamp state
    input  wire logic [11:0] i_gate,
    output logic             o_zc_n = 1'b1,
    output logic [11:0]      o_lamp = '0
);
    int unsigned cnt = 0;
    // Crossing pulse, moved off the sampling edge
    always @(negedge i_clk) begin
        cnt = (i_run && cnt + 1 < i_half) ? cnt + 1 : 0;
        o_zc_n <= !(i_run && cnt < 2);
    end
    // Relay fires at any phase, lamp latched until the crossing
    always @(posedge i_clk) begin
        for (int k = 0; k < 12; k++) begin
            o_lamp[k] <= o_zc_n ? (o_lamp[k] | i_gate[k]) : i_gate[k];
        end
    end
endmodule // pads_mains_model
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the dimmer scheduler
// Assumes: Short tick and pulse parameters
// Notes:   Rounds are measured from the sampled crossing
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int TICK = 4;
    localparam int PUL  = 3;
    logic        clk    = 1'b0;
    logic        i_rst  = 1'b1;
    logic        i_ce   = 1'b1;
    logic        en     = 1'b0;
    logic        run    = 1'b0;
    logic        chk_zc = 1'b0;
    logic        zc_d1  = 1'b1;
    logic [15:0] half   = 16'h00c8;
    logic [11:0] fire;
    logic [11:0] fire_q = '0;
    logic [11:0] lamp;
    logic        zc_n;
    logic        zc_cnt;
    pads_pkg::pads_zc_stat_t stat;
    pads_pkg::pads_ch_cfg_t  cfg [12];
    int num_errors = 0;
    int check_count = 0;
    int since = 0;
    int rise_at [12];
    int width [12];
    int kind [12];
    int dly [12];

    initial begin
        forever #12.5 clk = ~clk;
    end

    pads_top #(.TICK_CYC(TICK), .PULSE_CYC(PUL)) pads_top_i (.i_clk(clk), .i_rst(i_rst),
        .i_ce(i_ce), .i_zc_n(zc_n), .i_zc_irq_en(en), .i_cfg(cfg), .o_fire(fire),
        .o_zc_for_counter(zc_cnt), .o_zc_stat(stat));
    pads_mains_model pads_mains_model_i (.i_clk(clk), .i_run(run), .i_half(half),
        .i_gate(fire), .o_zc_n(zc_n), .o_lamp(lamp));

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_win(input string what, input int lo, input int hi, input int got);
        check_count++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic test_done();
        $display("Errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    function automatic int exp_rise(input int d);
        return 2 + d * TICK;
    endfunction

    // Per-round records, cleared at each sampled crossing
    always @(posedge clk) begin
        since = (zc_d1 && !zc_n) ? 0 : since + 1;
        for (int k = 0; k < 12; k++) begin
            if (since == 0) begin
                rise_at[k] = -1;
                width[k] = 0;
            end
            // The crossing edge still shows the last round's drive, so skip it
            if (since > 0 && fire[k] === 1'b1 && fire_q[k] !== 1'b1) rise_at[k] = since;
            if (since > 0 && fire[k] === 1'b1) width[k] = width[k] + 1;
        end
        if (chk_zc) chk_val("zc_counter", zc_d1, zc_cnt);
        zc_d1 = zc_n;
        fire_q = fire;
    end

    // Bounded wait for a position within the round
    task automatic wait_since(input int t);
        int n;
        n = 0;
        while (since != t && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) begin
            num_errors++;
            test_done();
        end
    endtask

    // Kind 0 off, 1 held on, 2 dim, 3 dim with delay zero
    task automatic set_ch(input int k, input int t, input int d);
        kind[k] = t;
        dly[k] = d;
        cfg[k].mode = (t == 0) ? pads_pkg::PADS_MODE_OFF :
                      (t == 1) ? pads_pkg::PADS_MODE_ON : pads_pkg::PADS_MODE_DIM;
        cfg[k].delay = (t == 3) ? 8'h00 : 8'(d);
    endtask

    // Run one round with the present settings, then judge it when judge is set
    task automatic round(input bit judge);
        int hp;
        int er;
        hp = int'(half);
        wait_since(0);
        wait_since(hp - 1);
        for (int k = 0; k < 12 && judge; k++) begin
            er = exp_rise(dly[k]);
            if (kind[k] == 1) begin
                chk_win("on_width", hp - 2, hp, width[k]);
                chk_val("lamp", 1, lamp[k]);
            end else if (kind[k] == 2 && en && er + PUL + 3 < hp) begin
                chk_win("rise", er - 2, er + 2, rise_at[k]);
                chk_val("width", PUL, width[k]);
                chk_val("lamp_dim", 1, lamp[k]);
            end else if (kind[k] == 2 && en) begin
                chk_val("cancel", 0, width[k]);
                chk_val("lamp_cut", 0, lamp[k]);
            end else if (kind[k] == 3) begin
                chk_val("zero_dly", 0, width[k]);
            end else begin
                chk_val("quiet", 0, width[k]);
                chk_val("lamp_off", 0, lamp[k]);
            end
        end
    endtask

    initial begin
        void'($urandom(31));
        for (int k = 0; k < 12; k++) set_ch(k, 2, 5);
        repeat (2) @(negedge clk);
        i_rst = 1'b0;
        chk_val("fire_rst", 0, fire);
        chk_val("stat_rst", 0, stat);
        run = 1'b1;
        chk_zc = 1'b1;
        round(1'b0);
        round(1'b1);
        chk_zc = 1'b0;
        en = 1'b1;
        round(1'b0);
        for (int r = 0; r < 9; r++) begin
            for (int k = 0; k < 12; k++) begin
                if (r == 0) set_ch(k, 2, k + 1);
                else if (r == 1) set_ch(k, 2, 45 - k);
                else if (r < 5) set_ch(k, 2, $urandom_range(45, 1));
                else set_ch(k, $urandom_range(3, 0), $urandom_range(45, 1));
            end
            // Hand-written corners on channels one and twelve
            if (r == 2) set_ch(0, 3, 0);
            if (r == 3) begin
                set_ch(0, 1, 0);
                set_ch(11, 1, 0);
            end
            if (r == 4) set_ch(0, 0, 0);
            round(1'b1);
            chk_val("zc_counter", 1, zc_cnt);
            chk_val("stat", 3, stat);
        end
        // Short half cycle: long delays never reach their slot
        half = 16'h0064;
        for (int k = 0; k < 12; k++) set_ch(k, 2, (k % 2) ? 10 : 30);
        round(1'b0);
        round(1'b1);
        round(1'b1);
        en = 1'b0;
        round(1'b0);
        round(1'b1);
        chk_val("stat_off", 0, stat);
        test_done();
    end
endmodule // testbench
`default_nettype wire
